// file: logic/reset_seq_pkg.sv
// constants for the reset sequencer and low-voltage detector
package reset_seq_pkg;
    // register map (byte addresses on the local port)
    localparam logic [3:0] ADDR_DETECTOR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RESET_CAUSE = 4'h1;
    localparam logic [3:0] ADDR_CORE_STATUS = 4'h2;
    localparam logic [3:0] ADDR_CORE_CTRL = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h5;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h6;
    // detector control fields
    localparam int STABLE_BIT = 5;
    localparam int POWER_BIT = 4;
    localparam logic [3:0] TRIP_LEVEL_RESET = 4'h5;
    localparam logic [3:0] TRIP_LEVEL_EXTERNAL = 4'hF;
    // reset cause fields
    localparam int CAUSE_SPARE_BIT = 2;
    localparam int POR_N_BIT = 1;
    localparam int BOR_N_BIT = 0;
    // core status fields: bank bits 7:5, timeout 4, powerdown 3
    localparam int TIMEOUT_BIT = 4;
    localparam int POWERDOWN_BIT = 3;
    localparam int BANK_LSB = 5;
    // core control fields
    localparam int GLOBAL_IRQ_BIT = 0;
    // interrupt event bits
    localparam int IRQ_TRIP_BIT = 0;
    localparam int IRQ_STABLE_BIT = 1;
    localparam int IRQ_W = 2;
    // program counter load values
    localparam int PC_W = 13;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    // oscillator modes taken from the straps
    localparam logic [2:0] LOW_POWER_CRYSTAL_MODE = 3'h0;
    localparam logic [2:0] CRYSTAL_MODE = 3'h1;
    localparam logic [2:0] HIGH_SPEED_CRYSTAL_MODE = 3'h2;
    localparam logic [2:0] EXTERNAL_RC_MODE = 3'h3;
    localparam logic [2:0] INTERNAL_RC_MODE = 3'h4;
    localparam logic [2:0] SECONDARY_OSCILLATOR = 3'h5;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int REF_SETTLE_NS = 50000;
    localparam int CPU_DELAY_NS = 5000;
    localparam int REF_SETTLE_CYCLES = REF_SETTLE_NS / CLK_PERIOD_NS;
    localparam int CPU_DELAY_CYCLES = (CPU_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OST_OSC_CYCLES = 1024;
    localparam int TIMER_W = 24;
    // sequencer states
    typedef enum logic [6:0] {
        ST_BROWNOUT = 7'b0000001,
        ST_POWERUP = 7'b0000010,
        ST_OSC_START = 7'b0000100,
        ST_CPU_DELAY = 7'b0001000,
        ST_PIN_HOLD = 7'b0010000,
        ST_RUN = 7'b0100000,
        ST_SLEEP = 7'b1000000
    } seq_state_e;
endpackage

// file: logic/reset_sequencer.sv
// reset sequencing, reset cause flags and low-voltage detector control
// How it works
// - stable flag rises once reference settles
// - reference settles within 50 us
// - trip flag blocked until reference stable
// - trip crossing sets flag, wakes sleep
// - interrupt wake with global enable loads 0004h
// - any reset turns the detector off
// - power-up timer, then 1024 oscillator cycles in crystal modes
// - held reset pin releases with no delay
// - CPU start-up delay on power-on, brown-out, wake
// - brown-out reset clears brown-out status bit
// - power-on status cleared only by power-on or a software write
// - timeout and powerdown flags follow reset type
// - resets load 000h, wakes without the 0004h vector continue PC+1
// - status and cause initial patterns per reset
// - level 1111 selects external sense pin
// - control layout: stable 5, power 4, level 3:0
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int REF_SETTLE = reset_seq_pkg::REF_SETTLE_CYCLES,
    parameter int POWERUP_CYCLES = 65536
)(
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic irq,
    input wire logic external_reset_pin_n,
    input wire logic brownout_detect,
    input wire logic brownout_enable,
    input wire logic below_trip,
    input wire logic osc_in,
    input wire logic powerup_timer_enable_n,
    input wire logic [2:0] osc_mode,
    input wire logic watchdog_timeout,
    input wire logic sleep_request,
    output logic core_reset,
    output logic core_run,
    output logic pc_load,
    output logic [reset_seq_pkg::PC_W-1:0] pc_load_value,
    output logic pc_resume,
    output logic detector_power,
    output logic external_sense_select
);
    import reset_seq_pkg::*;

    localparam logic [TIMER_W-1:0] REF_LAST = TIMER_W'(REF_SETTLE - 1);
    localparam logic [TIMER_W-1:0] POWERUP_TIMER_LAST = TIMER_W'(POWERUP_CYCLES - 1);
    localparam logic [TIMER_W-1:0] CPU_LAST = TIMER_W'(CPU_DELAY_CYCLES - 1);
    localparam logic [TIMER_W-1:0] OST_LAST = TIMER_W'(OST_OSC_CYCLES - 1);

    seq_state_e state_reg, state_next;
    logic [TIMER_W-1:0] timer_reg, settle_reg;
    logic [4:0] pin_sync_reg, bor_sync_reg, trip_sync_reg, osc_sync_reg, bore_sync_reg;
    logic osc_last_reg, trip_last_reg;
    logic strap_valid_reg, powerup_timer_off_reg;
    logic [2:0] mode_reg;
    logic wake_reg, vector_reg;
    logic [3:0] trip_level_reg;
    logic power_reg, stable_reg, stable_last_reg;
    logic [2:0] cause_reg;
    logic [2:0] bank_reg;
    logic timeout_reg, powerdown_reg, global_reg;
    logic [IRQ_W-1:0] irq_status_reg, irq_enable_reg, irq_event;
    logic pin_n, bor_s, trip_s, osc_s, bor_on, osc_edge, crystal, trip_event;
    logic ev_bor, ev_pin_run, ev_pin_sleep, ev_wdt_reset, ev_wdt_wake, ev_irq_wake;
    logic ev_sleep, dev_reset, wr_ctrl;

    // two-stage synchronisers for pins; stage 1 only feeds stage 2
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pin_sync_reg <= 5'h00;
            bor_sync_reg <= 5'h00;
            trip_sync_reg <= 5'h00;
            osc_sync_reg <= 5'h00;
            bore_sync_reg <= 5'h00;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[3:0], external_reset_pin_n};
            bor_sync_reg <= {bor_sync_reg[3:0], brownout_detect};
            trip_sync_reg <= {trip_sync_reg[3:0], below_trip};
            osc_sync_reg <= {osc_sync_reg[3:0], osc_in};
            bore_sync_reg <= {bore_sync_reg[3:0], brownout_enable};
        end
    end
    assign pin_n = pin_sync_reg[1];
    assign bor_s = bor_sync_reg[1];
    assign trip_s = trip_sync_reg[1];
    assign osc_s = osc_sync_reg[1];
    assign bor_on = bore_sync_reg[1];

    // edge detection after synchronisation
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            osc_last_reg <= 1'b0;
            trip_last_reg <= 1'b0;
        end
        else
        begin
            osc_last_reg <= osc_s;
            trip_last_reg <= trip_s;
        end
    end
    assign osc_edge = osc_s & ~osc_last_reg;
    assign trip_event = trip_s & ~trip_last_reg & power_reg & stable_reg;

    // straps caught once after reset release
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            strap_valid_reg <= 1'b0;
            powerup_timer_off_reg <= 1'b0;
            mode_reg <= LOW_POWER_CRYSTAL_MODE;
        end
        else if (!strap_valid_reg)
        begin
            strap_valid_reg <= 1'b1;
            powerup_timer_off_reg <= powerup_timer_enable_n;
            mode_reg <= osc_mode;
        end
    end
    assign crystal = (mode_reg == LOW_POWER_CRYSTAL_MODE) || (mode_reg == CRYSTAL_MODE)
        || (mode_reg == HIGH_SPEED_CRYSTAL_MODE);

    // reset and wake events
    always_comb
    begin
        ev_bor = bor_on & bor_s & (state_reg != ST_BROWNOUT);
        ev_pin_run = ~pin_n & (state_reg == ST_RUN);
        ev_pin_sleep = ~pin_n & (state_reg == ST_SLEEP);
        ev_wdt_reset = watchdog_timeout & (state_reg == ST_RUN) & ~ev_pin_run;
        ev_wdt_wake = watchdog_timeout & (state_reg == ST_SLEEP) & ~ev_pin_sleep;
        ev_irq_wake = trip_event & (state_reg == ST_SLEEP) & ~ev_pin_sleep & ~watchdog_timeout;
        ev_sleep = sleep_request & (state_reg == ST_RUN) & ~ev_pin_run & ~watchdog_timeout;
        dev_reset = ev_bor | ev_pin_run | ev_pin_sleep | ev_wdt_reset;
    end

    // sequencer next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_BROWNOUT:
                if (!(bor_on & bor_s))
                    state_next = ST_POWERUP;
            ST_POWERUP:
                if (strap_valid_reg && (powerup_timer_off_reg || timer_reg == POWERUP_TIMER_LAST))
                    state_next = crystal ? ST_OSC_START : ST_CPU_DELAY;
            ST_OSC_START:
                if (osc_edge && timer_reg == OST_LAST)
                    state_next = ST_CPU_DELAY;
            ST_CPU_DELAY:
                if (timer_reg == CPU_LAST)
                    state_next = wake_reg ? ST_RUN : ST_PIN_HOLD;
            ST_PIN_HOLD:
                if (pin_n)
                    state_next = ST_RUN;
            ST_RUN:
                if (ev_pin_run || ev_wdt_reset)
                    state_next = ST_PIN_HOLD;
                else if (ev_sleep)
                    state_next = ST_SLEEP;
            ST_SLEEP:
                if (ev_pin_sleep)
                    state_next = ST_PIN_HOLD;
                else if (ev_wdt_wake || ev_irq_wake)
                    state_next = crystal ? ST_OSC_START : ST_CPU_DELAY;
            default:
                state_next = ST_POWERUP;
        endcase
        if (ev_bor)
            state_next = ST_BROWNOUT;
    end

    // state, delay timer and wake bookkeeping
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_POWERUP;
            timer_reg <= '0;
            wake_reg <= 1'b0;
            vector_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next != state_reg)
                timer_reg <= '0;
            else if (state_reg != ST_OSC_START || osc_edge)
                timer_reg <= timer_reg + 1'b1;
            if (ev_wdt_wake || ev_irq_wake)
                wake_reg <= 1'b1;
            else if (dev_reset || state_reg == ST_RUN)
                wake_reg <= 1'b0;
            if (ev_wdt_wake || ev_irq_wake)
                vector_reg <= ev_irq_wake & global_reg;
        end
    end

    // core control outputs and program counter load
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            core_reset <= 1'b1;
            core_run <= 1'b0;
            pc_load <= 1'b0;
            pc_load_value <= RESET_VECTOR;
            pc_resume <= 1'b0;
        end
        else
        begin
            core_reset <= (state_next != ST_RUN) && (state_next != ST_SLEEP);
            core_run <= state_next == ST_RUN;
            pc_load <= (state_next == ST_RUN) && (state_reg != ST_RUN);
            if ((state_next == ST_RUN) && (state_reg != ST_RUN))
            begin
                pc_resume <= wake_reg & ~vector_reg;
                pc_load_value <= (wake_reg && vector_reg) ? IRQ_VECTOR : RESET_VECTOR;
            end
        end
    end

    // detector control register
    assign wr_ctrl = wr_en && addr == ADDR_DETECTOR_CTRL;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            trip_level_reg <= TRIP_LEVEL_RESET;
            power_reg <= 1'b0;
            external_sense_select <= 1'b0;
            detector_power <= 1'b0;
        end
        else if (dev_reset)
        begin
            trip_level_reg <= TRIP_LEVEL_RESET;
            power_reg <= 1'b0;
            external_sense_select <= 1'b0;
            detector_power <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                trip_level_reg <= wr_data[3:0];
                power_reg <= wr_data[POWER_BIT];
            end
            external_sense_select <= trip_level_reg == TRIP_LEVEL_EXTERNAL;
            detector_power <= power_reg;
        end
    end

    // reference settling counted in fixed clock periods
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            settle_reg <= '0;
            stable_reg <= 1'b0;
        end
        else if (!power_reg)
        begin
            settle_reg <= '0;
            stable_reg <= 1'b0;
        end
        else if (bor_on || settle_reg == REF_LAST)
            stable_reg <= 1'b1;
        else
            settle_reg <= settle_reg + 1'b1;
    end

    // reset cause flags
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cause_reg <= 3'h4;
        end
        else
        begin
            // software, power-on or brown-out changes it
            if (wr_en && addr == ADDR_RESET_CAUSE)
                cause_reg <= wr_data[2:0];
            if (ev_bor)
            begin
                cause_reg[BOR_N_BIT] <= 1'b0;
                cause_reg[CAUSE_SPARE_BIT] <= 1'b1;
            end
        end
    end

    // timeout, powerdown and bank bits of the core status
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            timeout_reg <= 1'b1;
            powerdown_reg <= 1'b1;
            bank_reg <= 3'h0;
        end
        else
        begin
            if (wr_en && addr == ADDR_CORE_STATUS)
                bank_reg <= wr_data[7:BANK_LSB];
            if (dev_reset)
                bank_reg <= 3'h0;
            if (ev_bor)
            begin
                timeout_reg <= 1'b1;
                powerdown_reg <= 1'b1;
            end
            else if (ev_wdt_reset)
            begin
                timeout_reg <= 1'b0;
                powerdown_reg <= 1'b1;
            end
            else if (ev_wdt_wake)
            begin
                timeout_reg <= 1'b0;
                powerdown_reg <= 1'b0;
            end
            else if (ev_pin_sleep || ev_irq_wake || ev_sleep)
            begin
                timeout_reg <= 1'b1;
                powerdown_reg <= 1'b0;
            end
        end
    end

    // global enable, interrupt enable and sticky status
    // previous stable level, for the rising-edge event
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            stable_last_reg <= 1'b0;
        else
            stable_last_reg <= stable_reg;
    end
    assign irq_event = {stable_reg & ~stable_last_reg, trip_event};
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            global_reg <= 1'b0;
            irq_enable_reg <= '0;
            irq_status_reg <= '0;
        end
        else if (dev_reset)
        begin
            global_reg <= 1'b0;
            irq_enable_reg <= '0;
            irq_status_reg <= irq_event;
        end
        else
        begin
            if (wr_en && addr == ADDR_CORE_CTRL)
                global_reg <= wr_data[GLOBAL_IRQ_BIT];
            if (wr_en && addr == ADDR_IRQ_ENABLE)
                irq_enable_reg <= wr_data[IRQ_W-1:0];
            if (wr_en && addr == ADDR_IRQ_CLEAR)
                irq_status_reg <= (irq_status_reg & ~wr_data[IRQ_W-1:0]) | irq_event;
            else
                irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    // interrupt output and read data
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
            rd_data <= 8'h00;
        end
        else
        begin
            irq <= (irq_status_reg[IRQ_TRIP_BIT] & irq_enable_reg[IRQ_TRIP_BIT] & global_reg)
                | (irq_status_reg[IRQ_STABLE_BIT] & irq_enable_reg[IRQ_STABLE_BIT]);
            rd_data <= 8'h00;
            if (rd_en)
            begin
                case (addr)
                    ADDR_DETECTOR_CTRL:
                        rd_data <= {2'b00, stable_reg, power_reg, trip_level_reg};
                    ADDR_RESET_CAUSE:
                        rd_data <= {5'h00, cause_reg};
                    ADDR_CORE_STATUS:
                        rd_data <= {bank_reg, timeout_reg, powerdown_reg, 3'h0};
                    ADDR_CORE_CTRL:
                        rd_data <= {7'h00, global_reg};
                    ADDR_IRQ_STATUS:
                        rd_data <= {6'h00, irq_status_reg};
                    ADDR_IRQ_ENABLE:
                        rd_data <= {6'h00, irq_enable_reg};
                    default:
                        rd_data <= 8'h00;
                endcase
            end
        end
    end

    // checks
    logic [TIMER_W-1:0] on_cnt_reg;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            on_cnt_reg <= '0;
        else if (!power_reg || stable_reg)
            on_cnt_reg <= '0;
        else
            on_cnt_reg <= on_cnt_reg + 1'b1;
    end

    property p_stable_needs_power;
        @(posedge clock) disable iff (rst) $rose(stable_reg) |-> $past(power_reg);
    endproperty
    a_stable_needs_power: assert property (p_stable_needs_power) else $error("stable without power");
    property p_settle_bound;
        @(posedge clock) disable iff (rst) on_cnt_reg <= TIMER_W'(REF_SETTLE);
    endproperty
    a_settle_bound: assert property (p_settle_bound) else $error("reference settle too long");
    property p_trip_after_stable;
        @(posedge clock) disable iff (rst) $rose(irq_status_reg[IRQ_TRIP_BIT]) |-> $past(stable_reg);
    endproperty
    a_trip_after_stable: assert property (p_trip_after_stable) else $error("trip before stable");
    property p_trip_wakes;
        @(posedge clock) disable iff (rst) ev_irq_wake |=> state_reg != ST_SLEEP ##1 !core_run;
    endproperty
    a_trip_wakes: assert property (p_trip_wakes) else $error("trip did not wake");
    property p_vector;
        @(posedge clock) disable iff (rst) pc_load && pc_load_value == IRQ_VECTOR |-> !pc_resume;
    endproperty
    a_vector: assert property (p_vector) else $error("vector with resume");
    property p_reset_detector_off;
        @(posedge clock) disable iff (rst) dev_reset |=> !power_reg ##1 !detector_power;
    endproperty
    a_reset_detector_off: assert property (p_reset_detector_off) else $error("detector on after reset");
    property p_ost_start;
        @(posedge clock) disable iff (rst)
            state_reg == ST_OSC_START && $past(state_reg) != ST_OSC_START |-> timer_reg == '0;
    endproperty
    a_ost_start: assert property (p_ost_start) else $error("oscillator count not cleared");
    property p_pin_release;
        @(posedge clock) disable iff (rst) state_reg == ST_PIN_HOLD && pin_n |=> core_run && pc_load;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("held pin release delayed");
    property p_por_flag_kept;
        @(posedge clock) disable iff (rst)
            $fell(cause_reg[POR_N_BIT]) |-> $past(wr_en && addr == ADDR_RESET_CAUSE);
    endproperty
    a_por_flag_kept: assert property (p_por_flag_kept) else $error("power-on flag cleared");
    property p_wdt_flags;
        @(posedge clock) disable iff (rst) ev_wdt_reset |=> !timeout_reg && powerdown_reg;
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog flags wrong");
    c_run: cover property (@(posedge clock) disable iff (rst) $rose(core_run));
    c_sleep_wake: cover property (@(posedge clock) disable iff (rst) ev_irq_wake);
    c_stable: cover property (@(posedge clock) disable iff (rst) $rose(stable_reg));
endmodule
`default_nettype wire

// file: bench/supply_pin_model.sv
// supply monitors, reset pin and crystal facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module supply_pin_model #(
    parameter int OSC_HALF_NS = 15
)(
    input wire logic pin_low,
    input wire logic brown,
    input wire logic trip,
    output logic external_reset_pin_n,
    output logic brownout_detect,
    output logic below_trip,
    output var logic osc_in
);
    // crystal runs free, slower than a quarter of the clock
    initial osc_in = 1'b0;
    always #(OSC_HALF_NS) osc_in = ~osc_in;
    // pin and monitor levels held for whole spans
    assign external_reset_pin_n = ~pin_low;
    assign brownout_detect = brown;
    assign below_trip = trip;
endmodule
`default_nettype wire

// file: bench/reset_sequencer_test.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer_test;
    import reset_seq_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic pin_low = 1'b0, brown = 1'b0, trip = 1'b0, be = 1'b0, wdog = 1'b0, slp = 1'b0;
    logic [7:0] rd_data;
    logic irq, core_reset, core_run, pc_load, pc_resume, det_pwr, ext_sel;
    logic pin_n, bdet, below, osc;
    logic [12:0] pc_val;
    logic [12:0] last_pc = 13'h1FFF;
    int miscompares = 0, comparisons = 0;
    always #2.5 clock = ~clock;
    supply_pin_model sup (.pin_low(pin_low), .brown(brown), .trip(trip),
        .external_reset_pin_n(pin_n), .brownout_detect(bdet), .below_trip(below), .osc_in(osc));
    reset_sequencer #(.REF_SETTLE(20), .POWERUP_CYCLES(16)) uut (.clock(clock), .rst(rst),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .irq(irq), .external_reset_pin_n(pin_n), .brownout_detect(bdet), .brownout_enable(be),
        .below_trip(below), .osc_in(osc), .powerup_timer_enable_n(1'b0), .osc_mode(3'h1),
        .watchdog_timeout(wdog), .sleep_request(slp), .core_reset(core_reset),
        .core_run(core_run), .pc_load(pc_load), .pc_load_value(pc_val), .pc_resume(pc_resume),
        .detector_power(det_pwr), .external_sense_select(ext_sel));
    // remember the last program counter load
    always @(posedge clock)
        if (pc_load)
            last_pc <= pc_val;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one-cycle bus strobes
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 check({8'h00, rd_data}, {8'h00, exp});
    endtask
    task automatic wait_run(input int limit);
        int n;
        n = 0;
        while (core_run !== 1'b1 && n < limit)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check({15'h0, core_run}, 16'h1);
        repeat (2) @(posedge clock);
    endtask
    task automatic pulse(input int which);
        @(posedge clock);
        if (which == 0) slp <= 1'b1; else wdog <= 1'b1;
        @(posedge clock);
        slp <= 1'b0;
        wdog <= 1'b0;
    endtask
    // run limit, well past the expected length
    initial
    begin
        #400000;
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        realtime t0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t0 = $realtime;
        #1 check({15'h0, core_reset}, 16'h1);
        rd(ADDR_DETECTOR_CTRL, 8'h05);
        rd(ADDR_RESET_CAUSE, 8'h04);
        rd(ADDR_CORE_STATUS, 8'h18);
        rd(4'hF, 8'h00);
        wait_run(20000);
        check({15'h0, ($realtime - t0) >= 1024 * 30}, 16'h1);
        check({3'h0, last_pc}, {3'h0, RESET_VECTOR});
        $display("test startup done");
        wr(ADDR_DETECTOR_CTRL, 8'h1F);
        rd(ADDR_DETECTOR_CTRL, 8'h1F);
        repeat (30) @(posedge clock);
        rd(ADDR_DETECTOR_CTRL, 8'h3F);
        check({14'h0, det_pwr, ext_sel}, 16'h3);
        wr(ADDR_IRQ_CLEAR, 8'h03);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_CORE_CTRL, 8'h01);
        @(posedge clock) trip <= 1'b1;
        repeat (8) @(posedge clock);
        rd(ADDR_IRQ_STATUS, 8'h01);
        check({15'h0, irq}, 16'h1);
        wr(ADDR_CORE_CTRL, 8'h00);
        repeat (3) @(posedge clock);
        check({15'h0, irq}, 16'h0);
        wr(ADDR_IRQ_CLEAR, 8'h01);
        trip <= 1'b0;
        wr(ADDR_CORE_CTRL, 8'h01);
        $display("test detector done");
        pulse(0);
        repeat (4) @(posedge clock);
        check({15'h0, core_run}, 16'h0);
        trip <= 1'b1;
        wait_run(20000);
        check({3'h0, last_pc}, {3'h0, IRQ_VECTOR});
        check({15'h0, pc_resume}, 16'h0);
        rd(ADDR_CORE_STATUS, 8'h10);
        trip <= 1'b0;
        $display("test sleep wake done");
        pin_low <= 1'b1;
        repeat (8) @(posedge clock);
        check({14'h0, core_reset, det_pwr}, 16'h2);
        rd(ADDR_DETECTOR_CTRL, 8'h05);
        rd(ADDR_CORE_STATUS, 8'h10);
        last_pc <= 13'h1FFF;
        pin_low <= 1'b0;
        wait_run(8);
        check({3'h0, last_pc}, {3'h0, RESET_VECTOR});
        $display("test reset pin done");
        pulse(1);
        wait_run(20000);
        rd(ADDR_CORE_STATUS, 8'h08);
        $display("test watchdog done");
        wr(ADDR_RESET_CAUSE, 8'h07);
        be <= 1'b1;
        brown <= 1'b1;
        repeat (10) @(posedge clock);
        brown <= 1'b0;
        wait_run(20000);
        rd(ADDR_RESET_CAUSE, 8'h06);
        rd(ADDR_CORE_STATUS, 8'h18);
        $display("test brownout done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
